// ==== rtl/khp_pkg.sv ====
// constants, types and decode helpers for the keyboard/rtc host port
// assumes a single 10 MHz clock with a synchronous active-high reset
package khp_pkg;

  // isa i/o addresses, compared on the full 16-bit address
  localparam logic [15:0] KHP_ADDR_KBD_DATA = 16'h0060;
  localparam logic [15:0] KHP_ADDR_KBD_CMD = 16'h0064;
  localparam logic [15:0] KHP_ADDR_RTC_IDX = 16'h0070;
  localparam logic [15:0] KHP_ADDR_RTC_DAT = 16'h0071;
  localparam int KHP_SA2_POS = 2;

  // status register field positions and reset value
  localparam int KHP_ST_OBF = 0;
  localparam int KHP_ST_IBF = 1;
  localparam int KHP_ST_CD = 3;
  localparam logic [7:0] KHP_ST_UD_MASK = 8'hf4;
  localparam logic [7:0] KHP_ST_RESET = 8'h00;

  // controller port-2 bit positions
  localparam int KHP_P2_KRST = 0;
  localparam int KHP_P2_A20 = 1;
  localparam int KHP_P2_MOUSE_DATA_PIN = 2;
  localparam int KHP_P2_MCLK = 3;
  localparam int KHP_P2_KBD_HOST_IRQ = 4;
  localparam int KHP_P2_AIRQ = 5;
  localparam int KHP_P2_KBD_CLK_PIN = 6;
  localparam int KHP_P2_KBD_DATA_PIN = 7;

  // cmos storage
  localparam int KHP_CMOS_AW = 8;
  localparam int KHP_CMOS_DEPTH = 256;
  localparam logic [7:0] KHP_BYTE_ZERO = 8'h00;

  // which host port an address selects
  typedef enum logic [2:0] {
    KP_NONE,
    KP_DATA,
    KP_CMD,
    KP_RIDX,
    KP_RDAT
  } khp_port_e;

  // powerdown states
  typedef enum logic [1:0] {
    PD_RUN,
    PD_SOFT,
    PD_HARD
  } khp_pd_e;

  // isa bus sample, strobes active low
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic iow_n;
    logic ior_n;
    logic aen;
  } khp_isa_s;

  // open-drain pin drive pair
  typedef struct packed {
    logic o;
    logic oe;
  } khp_od_s;

  // address decode shared by the read and write paths
  function automatic khp_port_e khp_decode(input logic [15:0] addr);
    khp_port_e sel;
    sel = KP_NONE;
    if (addr == KHP_ADDR_KBD_DATA) sel = KP_DATA;
    else if (addr == KHP_ADDR_KBD_CMD) sel = KP_CMD;
    else if (addr == KHP_ADDR_RTC_IDX) sel = KP_RIDX;
    else if (addr == KHP_ADDR_RTC_DAT) sel = KP_RDAT;
    return sel;
  endfunction

endpackage

// ==== rtl/khp_cmos_ram.sv ====
// cmos byte store behind the rtc index/data ports
// assumes write and read addresses are stable for the cycle they are used
`timescale 1ns/1ps
module khp_cmos_ram
  import khp_pkg::*;
(
  // clock
  input wire logic clock,
  // write side
  input wire logic wr_en,
  input wire logic [KHP_CMOS_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read side
  input wire logic [KHP_CMOS_AW-1:0] rd_addr,
  output logic [7:0] rd_data_ff
);

  logic [7:0] mem [KHP_CMOS_DEPTH];

  // contents survive reset, so no reset here
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read of the selected location
  always_ff @(posedge clock) begin
    rd_data_ff <= mem[rd_addr];
  end

endmodule

// ==== rtl/khp_host_port.sv ====
// host port of the embedded keyboard controller: isa buffers, flags, irqs, rtc ports, pins, powerdown
// assumes isa pins are asynchronous and held several clocks; cpu-side strobes are one-cycle pulses on clock
//
// Behaviour
// - host data-port write loads input buffer, clears command flag, sets input-full
// - host command-port write loads input buffer, sets command flag, sets input-full
// - host data read returns output buffer; with flags enabled clears irq and output-full
// - host read of command port returns the status register
// - keyboard and rtc decodes accepted only while aen is low
// - host write to rtc index stores the cmos location
// - rtc data port reads and writes the indexed cmos location
// - cpu output write loads host data and sets output-full in status bit 0
// - cpu input read returns host byte and clears input-full
// - every host data-port or command-port write copies address bit sa2 into status bit 3
// - flags enabled: keyboard irq is output-full while its port bit is one, else low
// - flags disabled: keyboard irq follows its port bit
// - flags enabled and aux bit one: aux irq is inverted input-full
// - flags disabled: aux irq follows its port bit
// - after reset the keyboard irq is zero
// - a20 port bit can be routed to a general-purpose pin
// - keyboard reset bit selectable onto a gpio pin, optionally resets watchdog
// - four port bits drive open-drain pins inverted, each pin sampled back
// - halt enters soft powerdown: alu clock stops, timer and interrupts run
// - soft powerdown ends on reset or host input write; call irq or resume
// - stop disables oscillator; same wake events; reset held for oscillator start
// - controller cpu has two interrupts: input-full and timer overflow
// - status: bit0 output-full, bit1 input-full, bit3 command; reset clears; host read-only
`timescale 1ns/1ps
module khp_host_port
  import khp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // isa host bus pins
  input wire logic [15:0] isa_addr,
  input wire logic [7:0] isa_wdata,
  input wire logic isa_iow_n,
  input wire logic isa_ior_n,
  input wire logic isa_aen,
  output logic [7:0] isa_rdata_ff,
  output logic isa_rdata_oe_ff,
  // host interrupts
  output logic kbd_host_irq,
  output logic aux_host_irq,
  // controller cpu data buffer
  input wire logic cpu_obuf_wr,
  input wire logic [7:0] cpu_obuf_wdata,
  input wire logic cpu_obf_clr,
  input wire logic cpu_ibuf_rd,
  output logic [7:0] cpu_input_buffer,
  input wire logic cpu_status_wr,
  input wire logic [7:0] cpu_status_wdata,
  output logic [7:0] cpu_status,
  // controller cpu port 2 and instructions
  input wire logic [7:0] cpu_port2,
  input wire logic cpu_en_flags,
  input wire logic cpu_halt,
  input wire logic cpu_stop,
  input wire logic cpu_ibf_int_en,
  input wire logic cpu_timer_ovf,
  // controller cpu interrupt and clock control
  output logic cpu_irq_ibf,
  output logic cpu_irq_timer,
  output logic alu_clk_en,
  output logic osc_en,
  output logic wake_call,
  output logic wake_next,
  // gpio alternate functions
  input wire logic a20_route_en,
  input wire logic kbd_reset_route_en,
  input wire logic wdt_reset_en,
  output logic gpio_a20_pin,
  output logic gpio_reset_pin,
  output logic wdt_reset,
  // keyboard and mouse open-drain pins
  input wire logic kbd_clk_pin_i,
  input wire logic kbd_data_pin_i,
  input wire logic mouse_clk_pin_i,
  input wire logic mouse_data_pin_i,
  output khp_od_s kbd_clk_pin,
  output khp_od_s kbd_data_pin,
  output khp_od_s mouse_clk_pin,
  output khp_od_s mouse_data_pin,
  output logic kbd_clk_sense,
  output logic kbd_data_sense,
  output logic mouse_clk_sense,
  output logic mouse_data_sense
);

  khp_isa_s isa_pin;
  khp_isa_s isa_s1_ff;
  khp_isa_s isa_s2_ff;
  khp_isa_s isa_prev_ff;
  logic [3:0] pin_s1_ff;
  logic [3:0] pin_s2_ff;
  logic [7:0] ibuf_ff;
  logic [7:0] obuf_ff;
  logic [7:0] ud_ff;
  logic obf_ff;
  logic ibf_ff;
  logic cd_ff;
  logic en_flags_ff;
  logic [7:0] rtc_index_ff;
  logic [7:0] cmos_rdata;
  logic kbd_host_irq_ff;
  logic airq_ff;
  logic nxt_kbd_host_irq;
  logic nxt_airq;
  khp_pd_e pd_ff;
  khp_pd_e nxt_pd;
  logic wake_call_ff;
  logic wake_next_ff;
  khp_port_e wr_sel;
  khp_port_e rd_sel;
  logic wr_evt;
  logic rd_act;
  logic rd_evt;
  logic host_in_wr;
  logic [7:0] status_w;
  logic [7:0] nxt_rdata;

  // two-stage sync of the isa pins, plus a delayed copy for edges
  assign isa_pin = '{addr: isa_addr, data: isa_wdata, iow_n: isa_iow_n, ior_n: isa_ior_n, aen: isa_aen};
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      isa_s1_ff <= '{addr: '0, data: '0, iow_n: 1'b1, ior_n: 1'b1, aen: 1'b1};
      isa_s2_ff <= '{addr: '0, data: '0, iow_n: 1'b1, ior_n: 1'b1, aen: 1'b1};
      isa_prev_ff <= '{addr: '0, data: '0, iow_n: 1'b1, ior_n: 1'b1, aen: 1'b1};
    end else begin
      isa_s1_ff <= isa_pin;
      isa_s2_ff <= isa_s1_ff;
      isa_prev_ff <= isa_s2_ff;
    end
  end

  // host strobe decode, gated by aen
  assign wr_sel = khp_decode(isa_s2_ff.addr);
  assign rd_sel = wr_sel;
  assign wr_evt = isa_prev_ff.iow_n & ~isa_s2_ff.iow_n & ~isa_s2_ff.aen;
  assign rd_act = ~isa_s2_ff.ior_n & ~isa_s2_ff.aen;
  assign rd_evt = rd_act & isa_prev_ff.ior_n;
  assign host_in_wr = wr_evt & ((wr_sel == KP_DATA) | (wr_sel == KP_CMD));

  // input buffer, written only by the host
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ibuf_ff <= KHP_BYTE_ZERO;
    end else if (host_in_wr) begin
      ibuf_ff <= isa_s2_ff.data;
    end
  end

  // input-full flag, a new host write wins over a cpu read
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ibf_ff <= 1'b0;
    end else if (host_in_wr) begin
      ibf_ff <= 1'b1;
    end else if (cpu_ibuf_rd) begin
      ibf_ff <= 1'b0;
    end
  end

  // command/data flag follows sa2 on each host data or command port write
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cd_ff <= 1'b0;
    end else if (host_in_wr) begin
      cd_ff <= isa_s2_ff.addr[KHP_SA2_POS];
    end
  end

  // cpu read of the input buffer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cpu_input_buffer <= KHP_BYTE_ZERO;
    end else if (cpu_ibuf_rd) begin
      cpu_input_buffer <= ibuf_ff;
    end
  end

  // output buffer, written only by the cpu
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      obuf_ff <= KHP_BYTE_ZERO;
    end else if (cpu_obuf_wr) begin
      obuf_ff <= cpu_obuf_wdata;
    end
  end

  // output-full flag, a cpu write wins over any clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      obf_ff <= 1'b0;
    end else if (cpu_obuf_wr) begin
      obf_ff <= 1'b1;
    end else if ((rd_evt & (rd_sel == KP_DATA) & en_flags_ff) | cpu_obf_clr) begin
      obf_ff <= 1'b0;
    end
  end

  // firmware-defined status bits
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ud_ff <= KHP_ST_RESET;
    end else if (cpu_status_wr) begin
      ud_ff <= cpu_status_wdata & KHP_ST_UD_MASK;
    end
  end

  // status assembly, host can only read it
  always_comb begin
    status_w = ud_ff;
    status_w[KHP_ST_OBF] = obf_ff;
    status_w[KHP_ST_IBF] = ibf_ff;
    status_w[KHP_ST_CD] = cd_ff;
  end
  assign cpu_status = status_w;

  // enable-flags latch, only reset turns it off
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      en_flags_ff <= 1'b0;
    end else if (cpu_en_flags) begin
      en_flags_ff <= 1'b1;
    end
  end

  // rtc index register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rtc_index_ff <= KHP_BYTE_ZERO;
    end else if (wr_evt & (wr_sel == KP_RIDX)) begin
      rtc_index_ff <= isa_s2_ff.data;
    end
  end

  // cmos store addressed by the index
  khp_cmos_ram u_cmos (
    .clock(clock),
    .wr_en(wr_evt & (wr_sel == KP_RDAT)),
    .wr_addr(rtc_index_ff),
    .wr_data(isa_s2_ff.data),
    .rd_addr(rtc_index_ff),
    .rd_data_ff(cmos_rdata)
  );

  // host read data mux
  always_comb begin
    nxt_rdata = KHP_BYTE_ZERO;
    unique case (rd_sel)
      KP_DATA: nxt_rdata = obuf_ff;
      KP_CMD: nxt_rdata = status_w;
      KP_RIDX: nxt_rdata = rtc_index_ff;
      KP_RDAT: nxt_rdata = cmos_rdata;
      KP_NONE: nxt_rdata = KHP_BYTE_ZERO;
    endcase
  end

  // registered host read data and its drive enable
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      isa_rdata_ff <= KHP_BYTE_ZERO;
      isa_rdata_oe_ff <= 1'b0;
    end else begin
      isa_rdata_ff <= nxt_rdata;
      isa_rdata_oe_ff <= rd_act & (rd_sel != KP_NONE);
    end
  end

  // host interrupt gating
  always_comb begin
    if (en_flags_ff) begin
      nxt_kbd_host_irq = cpu_port2[KHP_P2_KBD_HOST_IRQ] & obf_ff;
      nxt_airq = cpu_port2[KHP_P2_AIRQ] & ~ibf_ff;
    end else begin
      nxt_kbd_host_irq = cpu_port2[KHP_P2_KBD_HOST_IRQ];
      nxt_airq = cpu_port2[KHP_P2_AIRQ];
    end
  end

  // registered host interrupts, low out of reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      kbd_host_irq_ff <= 1'b0;
      airq_ff <= 1'b0;
    end else begin
      kbd_host_irq_ff <= nxt_kbd_host_irq;
      airq_ff <= nxt_airq;
    end
  end
  assign kbd_host_irq = kbd_host_irq_ff;
  assign aux_host_irq = airq_ff;

  // controller interrupt sources: input-full and timer overflow only
  assign cpu_irq_ibf = ibf_ff & cpu_ibf_int_en;
  assign cpu_irq_timer = cpu_timer_ovf;

  // powerdown state machine
  always_comb begin
    nxt_pd = pd_ff;
    unique case (pd_ff)
      PD_RUN: begin
        if (cpu_stop) nxt_pd = PD_HARD;
        else if (cpu_halt) nxt_pd = PD_SOFT;
      end
      PD_SOFT: begin
        if (host_in_wr) nxt_pd = PD_RUN;
      end
      PD_HARD: begin
        if (host_in_wr) nxt_pd = PD_RUN;
      end
    endcase
  end

  // state register; reset also wakes and restarts firmware at 0
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pd_ff <= PD_RUN;
    end else begin
      pd_ff <= nxt_pd;
    end
  end

  // wake pulses: interrupt call or next instruction
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wake_call_ff <= 1'b0;
      wake_next_ff <= 1'b0;
    end else begin
      wake_call_ff <= (pd_ff != PD_RUN) & host_in_wr & cpu_ibf_int_en;
      wake_next_ff <= (pd_ff != PD_RUN) & host_in_wr & ~cpu_ibf_int_en;
    end
  end
  assign wake_call = wake_call_ff;
  assign wake_next = wake_next_ff;
  assign alu_clk_en = (pd_ff == PD_RUN);
  assign osc_en = (pd_ff != PD_HARD);

  // gpio alternate outputs
  assign gpio_a20_pin = a20_route_en & cpu_port2[KHP_P2_A20];
  assign gpio_reset_pin = kbd_reset_route_en & cpu_port2[KHP_P2_KRST];
  assign wdt_reset = wdt_reset_en & cpu_port2[KHP_P2_KRST];

  // open-drain drive: bit high pulls pin low
  assign kbd_clk_pin = '{o: 1'b0, oe: cpu_port2[KHP_P2_KBD_CLK_PIN]};
  assign kbd_data_pin = '{o: 1'b0, oe: cpu_port2[KHP_P2_KBD_DATA_PIN]};
  assign mouse_clk_pin = '{o: 1'b0, oe: cpu_port2[KHP_P2_MCLK]};
  assign mouse_data_pin = '{o: 1'b0, oe: cpu_port2[KHP_P2_MOUSE_DATA_PIN]};

  // pin sense-back through two flops
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_s1_ff <= 4'hf;
      pin_s2_ff <= 4'hf;
    end else begin
      pin_s1_ff <= {mouse_data_pin_i, mouse_clk_pin_i, kbd_data_pin_i, kbd_clk_pin_i};
      pin_s2_ff <= pin_s1_ff;
    end
  end
  assign kbd_clk_sense = pin_s2_ff[0];
  assign kbd_data_sense = pin_s2_ff[1];
  assign mouse_clk_sense = pin_s2_ff[2];
  assign mouse_data_sense = pin_s2_ff[3];

  // host write steps
  sequence s_data_wr;
    wr_evt && (wr_sel == KP_DATA);
  endsequence

  sequence s_cmd_wr;
    wr_evt && (wr_sel == KP_CMD);
  endsequence

  sequence s_asleep_wr;
    (pd_ff != PD_RUN) && host_in_wr;
  endsequence

  chk_data_wr_flags: assert property (@(posedge clock) disable iff (sys_rst)
    s_data_wr |=> ibf_ff && !cd_ff && (ibuf_ff == $past(isa_s2_ff.data)))
    else $error("data write did not set input-full and clear command flag");

  chk_cmd_wr_flags: assert property (@(posedge clock) disable iff (sys_rst)
    s_cmd_wr |=> ibf_ff && cd_ff && status_w[KHP_ST_CD])
    else $error("command write did not set input-full and command flag");

  chk_data_rd_clr: assert property (@(posedge clock) disable iff (sys_rst)
    (rd_evt && rd_sel == KP_DATA && en_flags_ff && !cpu_obuf_wr) |=> !obf_ff ##1 !kbd_host_irq)
    else $error("flagged data read did not clear output-full and irq");

  chk_status_rd: assert property (@(posedge clock) disable iff (sys_rst)
    (rd_act && rd_sel == KP_CMD) |=> isa_rdata_oe_ff && (isa_rdata_ff == $past(status_w)))
    else $error("command port read did not return status");

  chk_aen_blocks: assert property (@(posedge clock) disable iff (sys_rst)
    isa_s2_ff.aen |=> $stable(ibuf_ff) && $stable(rtc_index_ff) && !isa_rdata_oe_ff)
    else $error("access accepted while aen high");

  chk_obuf_load: assert property (@(posedge clock) disable iff (sys_rst)
    cpu_obuf_wr |=> obf_ff && (obuf_ff == $past(cpu_obuf_wdata)))
    else $error("cpu output write did not load buffer and set output-full");

  chk_ibuf_read: assert property (@(posedge clock) disable iff (sys_rst)
    (cpu_ibuf_rd && !host_in_wr) |=> !ibf_ff && (cpu_input_buffer == $past(ibuf_ff)))
    else $error("cpu input read did not clear input-full");

  chk_kbd_host_irq_gate: assert property (@(posedge clock) disable iff (sys_rst)
    (en_flags_ff && !cpu_port2[KHP_P2_KBD_HOST_IRQ]) |=> !kbd_host_irq)
    else $error("keyboard irq not held low by port bit");

  chk_kbd_host_irq_direct: assert property (@(posedge clock) disable iff (sys_rst)
    !en_flags_ff |=> kbd_host_irq == $past(cpu_port2[KHP_P2_KBD_HOST_IRQ]))
    else $error("keyboard irq not following port bit");

  chk_airq_gate: assert property (@(posedge clock) disable iff (sys_rst)
    (en_flags_ff && cpu_port2[KHP_P2_AIRQ]) |=> aux_host_irq == !$past(ibf_ff))
    else $error("aux irq not inverted input-full");

  chk_kbd_host_irq_reset: assert property (@(posedge clock) disable iff (1'b0)
    sys_rst |=> !kbd_host_irq)
    else $error("keyboard irq high after reset");

  chk_wake_pulse: assert property (@(posedge clock) disable iff (sys_rst)
    s_asleep_wr |=> (pd_ff == PD_RUN) && alu_clk_en && (wake_call != wake_next))
    else $error("host write did not wake from powerdown");

  chk_halt_sleep: assert property (@(posedge clock) disable iff (sys_rst)
    (pd_ff == PD_RUN && cpu_halt && !cpu_stop) |=> !alu_clk_en && osc_en)
    else $error("halt did not enter soft powerdown");

endmodule

// ==== testbench/khp_isa_host.sv ====
// isa host model: byte writes and reads on the keyboard and rtc ports
// assumes pins change at the falling clock edge; read oe acts as the ready
`timescale 1ns/1ps
module khp_isa_host (
  // clock
  input wire logic clock,
  // isa pins driven by the host
  output logic [15:0] addr,
  output logic [7:0] wdata,
  output logic iow_n,
  output logic ior_n,
  output logic aen,
  // read return from the device
  input wire logic [7:0] rdata,
  input wire logic rdata_oe
);
  // idle bus from time zero
  initial begin
    addr = 16'h0000;
    wdata = 8'h00;
    iow_n = 1'b1;
    ior_n = 1'b1;
    aen = 1'b0;
  end

  // one byte write, strobe low four clocks then high four clocks
  task automatic io_write(input logic [15:0] a, input logic [7:0] d, input logic dma);
    @(negedge clock);
    addr = a;
    wdata = d;
    aen = dma;
    iow_n = 1'b0;
    repeat (4) @(posedge clock);
    @(negedge clock);
    iow_n = 1'b1;
    wdata = ~d; // released bus no longer shows the byte
    addr = ~a;
    aen = 1'b0;
    repeat (4) @(negedge clock);
  endtask

  // one byte read, held until the device drives data or eight clocks pass
  task automatic io_read(input logic [15:0] a, input logic dma, output logic [7:0] d, output logic ok);
    @(negedge clock);
    addr = a;
    aen = dma;
    ior_n = 1'b0;
    ok = 1'b0;
    d = 8'h00;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge clock);
      if (rdata_oe === 1'b1) begin
        ok = 1'b1;
        d = rdata;
      end
    end
    @(negedge clock);
    ior_n = 1'b1;
    addr = ~a;
    aen = 1'b0;
    repeat (5) @(negedge clock); // oe drops three clocks after release
  endtask
endmodule

// ==== testbench/test_kbd_ctrl_host_port.sv ====
// self-checking bench for the keyboard/rtc host port
// assumes the host model drives the isa pins; cpu side driven here at the falling edge
`timescale 1ns/1ps
module test_kbd_ctrl_host_port;
  import khp_pkg::*;
  logic clock = 1'b0;
  logic sys_rst;
  logic [15:0] isa_addr;
  logic [7:0] isa_wdata, isa_rdata_ff, cpu_obuf_wdata, cpu_input_buffer, cpu_status_wdata, cpu_status, cpu_port2;
  logic isa_iow_n, isa_ior_n, isa_aen, isa_rdata_oe_ff, kbd_host_irq, aux_host_irq;
  logic cpu_obuf_wr, cpu_obf_clr, cpu_ibuf_rd, cpu_status_wr, cpu_en_flags, cpu_halt, cpu_stop;
  logic cpu_ibf_int_en, cpu_timer_ovf, cpu_irq_ibf, cpu_irq_timer, alu_clk_en, osc_en, wake_call, wake_next;
  logic a20_route_en, kbd_reset_route_en, wdt_reset_en, gpio_a20_pin, gpio_reset_pin, wdt_reset;
  logic kbd_clk_pin_i, kbd_data_pin_i, mouse_clk_pin_i, mouse_data_pin_i, ext_low_n;
  logic kbd_clk_sense, kbd_data_sense, mouse_clk_sense, mouse_data_sense, ok;
  khp_od_s kbd_clk_pin, kbd_data_pin, mouse_clk_pin, mouse_data_pin;
  logic [7:0] rd;
  int errors = 0;
  int checked = 0;
  int n_call = 0;
  int n_next = 0;

  // open-drain wires with pull-ups; ext_low_n models a device pulling low
  assign kbd_clk_pin_i = ~(kbd_clk_pin.oe & ~kbd_clk_pin.o) & ext_low_n;
  assign kbd_data_pin_i = ~(kbd_data_pin.oe & ~kbd_data_pin.o) & ext_low_n;
  assign mouse_clk_pin_i = ~(mouse_clk_pin.oe & ~mouse_clk_pin.o) & ext_low_n;
  assign mouse_data_pin_i = ~(mouse_data_pin.oe & ~mouse_data_pin.o) & ext_low_n;

  khp_host_port i_dut (.clock(clock), .sys_rst(sys_rst), .isa_addr(isa_addr), .isa_wdata(isa_wdata),
    .isa_iow_n(isa_iow_n), .isa_ior_n(isa_ior_n), .isa_aen(isa_aen), .isa_rdata_ff(isa_rdata_ff),
    .isa_rdata_oe_ff(isa_rdata_oe_ff), .kbd_host_irq(kbd_host_irq), .aux_host_irq(aux_host_irq),
    .cpu_obuf_wr(cpu_obuf_wr), .cpu_obuf_wdata(cpu_obuf_wdata), .cpu_obf_clr(cpu_obf_clr),
    .cpu_ibuf_rd(cpu_ibuf_rd), .cpu_input_buffer(cpu_input_buffer), .cpu_status_wr(cpu_status_wr),
    .cpu_status_wdata(cpu_status_wdata), .cpu_status(cpu_status), .cpu_port2(cpu_port2),
    .cpu_en_flags(cpu_en_flags), .cpu_halt(cpu_halt), .cpu_stop(cpu_stop), .cpu_ibf_int_en(cpu_ibf_int_en),
    .cpu_timer_ovf(cpu_timer_ovf), .cpu_irq_ibf(cpu_irq_ibf), .cpu_irq_timer(cpu_irq_timer),
    .alu_clk_en(alu_clk_en), .osc_en(osc_en), .wake_call(wake_call), .wake_next(wake_next),
    .a20_route_en(a20_route_en), .kbd_reset_route_en(kbd_reset_route_en), .wdt_reset_en(wdt_reset_en),
    .gpio_a20_pin(gpio_a20_pin), .gpio_reset_pin(gpio_reset_pin), .wdt_reset(wdt_reset),
    .kbd_clk_pin_i(kbd_clk_pin_i), .kbd_data_pin_i(kbd_data_pin_i), .mouse_clk_pin_i(mouse_clk_pin_i),
    .mouse_data_pin_i(mouse_data_pin_i), .kbd_clk_pin(kbd_clk_pin), .kbd_data_pin(kbd_data_pin),
    .mouse_clk_pin(mouse_clk_pin), .mouse_data_pin(mouse_data_pin), .kbd_clk_sense(kbd_clk_sense),
    .kbd_data_sense(kbd_data_sense), .mouse_clk_sense(mouse_clk_sense), .mouse_data_sense(mouse_data_sense));

  khp_isa_host i_host (.clock(clock), .addr(isa_addr), .wdata(isa_wdata), .iow_n(isa_iow_n),
    .ior_n(isa_ior_n), .aen(isa_aen), .rdata(isa_rdata_ff), .rdata_oe(isa_rdata_oe_ff));

  // 10 MHz clock
  initial begin
    forever #50 clock = ~clock;
  end

  // count one-cycle wake pulses
  always @(posedge clock) begin
    if (wake_call === 1'b1) n_call++;
    if (wake_next === 1'b1) n_next++;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // op: 0 obuf write, 1 obf clear, 2 ibuf read, 3 status write, 4 enable flags, 5 halt, else stop
  task automatic cpu_pulse(input int op, input logic [7:0] d);
    @(negedge clock);
    cpu_obuf_wdata = d;
    cpu_status_wdata = d;
    case (op)
      0: cpu_obuf_wr = 1'b1;
      1: cpu_obf_clr = 1'b1;
      2: cpu_ibuf_rd = 1'b1;
      3: cpu_status_wr = 1'b1;
      4: cpu_en_flags = 1'b1;
      5: cpu_halt = 1'b1;
      default: cpu_stop = 1'b1;
    endcase
    @(negedge clock);
    {cpu_obuf_wr, cpu_obf_clr, cpu_ibuf_rd, cpu_status_wr, cpu_en_flags, cpu_halt, cpu_stop} = 7'h00;
    repeat (3) @(negedge clock);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    i_host.io_write(a, d, 1'b0);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    i_host.io_read(a, 1'b0, rd, ok);
    check({7'h00, ok}, 8'h01);
    check(rd, exp);
  endtask

  task automatic port2(input logic [7:0] v);
    @(negedge clock);
    cpu_port2 = v;
    repeat (4) @(negedge clock);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog well beyond the few hundred clocks the tests need
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    $display("watchdog expired at %0t", $time);
    wrap_up();
  end

  // main sequence
  initial begin
    sys_rst = 1'b1;
    {cpu_obuf_wr, cpu_obf_clr, cpu_ibuf_rd, cpu_status_wr, cpu_en_flags, cpu_halt, cpu_stop} = 7'h00;
    {cpu_ibf_int_en, cpu_timer_ovf, a20_route_en, kbd_reset_route_en, wdt_reset_en} = 5'h00;
    cpu_obuf_wdata = 8'h00;
    cpu_status_wdata = 8'h00;
    cpu_port2 = 8'h00;
    ext_low_n = 1'b1;
    repeat (6) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    check(cpu_status, KHP_ST_RESET);
    check({6'h00, kbd_host_irq, aux_host_irq}, 8'h00);
    check({2'b00, alu_clk_en, osc_en, kbd_clk_sense, kbd_data_sense, mouse_clk_sense, mouse_data_sense}, 8'h3f);
    $display("test reset done");

    rd_chk(KHP_ADDR_KBD_CMD, 8'h00);
    wr(KHP_ADDR_KBD_DATA, 8'ha5);
    check(cpu_status, 8'h02);
    cpu_pulse(2, 8'h00);
    check(cpu_input_buffer, 8'ha5);
    check(cpu_status, 8'h00);
    wr(KHP_ADDR_KBD_CMD, 8'h3c);
    check(cpu_status, 8'h0a);
    rd_chk(KHP_ADDR_KBD_CMD, 8'h0a);
    cpu_pulse(3, 8'hff);
    check(cpu_status, 8'hfe);
    cpu_pulse(0, 8'h5a);
    check(cpu_status, 8'hff);
    rd_chk(KHP_ADDR_KBD_DATA, 8'h5a);
    check(cpu_status, 8'hff);
    cpu_pulse(1, 8'h00);
    check(cpu_status, 8'hfe);
    cpu_pulse(2, 8'h00);
    check(cpu_input_buffer, 8'h3c);
    cpu_pulse(3, 8'h00);
    check(cpu_status, 8'h08);
    $display("test buffers done");

    for (int i = 0; i < 4; i++) begin
      port2({2'b00, i[1], i[0], 4'h0});
      check({6'h00, kbd_host_irq, aux_host_irq}, {6'h00, i[0], i[1]});
    end
    cpu_pulse(4, 8'h00);
    port2(8'h30);
    check({6'h00, kbd_host_irq, aux_host_irq}, 8'h01);
    cpu_pulse(0, 8'hc7);
    check({6'h00, kbd_host_irq, aux_host_irq}, 8'h03);
    wr(KHP_ADDR_KBD_DATA, 8'h11);
    check({5'h00, kbd_host_irq, aux_host_irq, cpu_irq_ibf}, 8'h04);
    cpu_ibf_int_en = 1'b1;
    cpu_timer_ovf = 1'b1;
    @(negedge clock);
    check({6'h00, cpu_irq_ibf, cpu_irq_timer}, 8'h03);
    cpu_timer_ovf = 1'b0;
    cpu_pulse(2, 8'h00);
    check({4'h0, kbd_host_irq, aux_host_irq, cpu_irq_ibf, cpu_irq_timer}, 8'h0c);
    port2(8'h20);
    check({6'h00, kbd_host_irq, aux_host_irq}, 8'h01);
    port2(8'h30);
    rd_chk(KHP_ADDR_KBD_DATA, 8'hc7);
    check(cpu_status, 8'h00);
    check({6'h00, kbd_host_irq, aux_host_irq}, 8'h01);
    $display("test interrupts done");

    i_host.io_write(KHP_ADDR_KBD_DATA, 8'h99, 1'b1);
    i_host.io_write(16'h0061, 8'h99, 1'b0);
    check(cpu_status, 8'h00);
    i_host.io_read(KHP_ADDR_KBD_CMD, 1'b1, rd, ok);
    check({7'h00, ok}, 8'h00);
    $display("test qualify done");

    wr(KHP_ADDR_RTC_IDX, 8'h12);
    wr(KHP_ADDR_RTC_DAT, 8'hc3);
    wr(KHP_ADDR_RTC_IDX, 8'h34);
    wr(KHP_ADDR_RTC_DAT, 8'h3d);
    wr(KHP_ADDR_RTC_IDX, 8'h12);
    rd_chk(KHP_ADDR_RTC_DAT, 8'hc3);
    rd_chk(KHP_ADDR_RTC_IDX, 8'h12);
    wr(KHP_ADDR_RTC_IDX, 8'h34);
    rd_chk(KHP_ADDR_RTC_DAT, 8'h3d);
    $display("test rtc done");

    for (int i = 0; i < 8; i++) begin
      a20_route_en = i[0];
      kbd_reset_route_en = i[1];
      wdt_reset_en = i[2];
      port2({i[2], ~i[2], 2'b00, i[1], i[0], 2'b11});
      check({kbd_clk_pin.oe, kbd_data_pin.oe, mouse_clk_pin.oe, mouse_data_pin.oe, kbd_clk_sense,
        kbd_data_sense, mouse_clk_sense, mouse_data_sense},
        {~i[2], i[2], i[1], i[0], i[2], ~i[2], ~i[1], ~i[0]});
      check({4'h0, kbd_clk_pin.o, kbd_data_pin.o, mouse_clk_pin.o, mouse_data_pin.o}, 8'h00);
      check({5'h00, gpio_a20_pin, gpio_reset_pin, wdt_reset}, {5'h00, i[0], i[1], i[2]});
    end
    port2(8'h00);
    ext_low_n = 1'b0;
    repeat (4) @(negedge clock);
    check({4'h0, kbd_clk_sense, kbd_data_sense, mouse_clk_sense, mouse_data_sense}, 8'h00);
    ext_low_n = 1'b1;
    $display("test pins done");

    cpu_pulse(5, 8'h00);
    check({6'h00, alu_clk_en, osc_en}, 8'h01);
    wr(KHP_ADDR_KBD_DATA, 8'h21);
    check({2'b00, alu_clk_en, osc_en, n_call[3:0]}, 8'h31);
    cpu_pulse(2, 8'h00);
    cpu_ibf_int_en = 1'b0;
    cpu_pulse(6, 8'h00);
    check({6'h00, alu_clk_en, osc_en}, 8'h00);
    wr(KHP_ADDR_KBD_CMD, 8'h22);
    check({alu_clk_en, osc_en, n_call[1:0], n_next[3:0]}, 8'hd1);
    // mid-run reset out of soft powerdown with status bits set
    cpu_pulse(5, 8'h00);
    sys_rst = 1'b1;
    repeat (6) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    check({alu_clk_en, osc_en, cpu_status[5:0]}, 8'hc0);
    $display("test powerdown done");
    wrap_up();
  end
endmodule
